//--- design/adcsf_pkg.sv
// Constants for the converter status flag register.
// Assumes an 8-bit special-function bus with byte and bit access.
package adcsf_pkg;
	// ****************************************
	// Register placement and reset
	// ****************************************
	localparam logic [7:0] ADCSF_ADDR      = 8'hd8; // Byte address
	localparam logic [7:0] ADCSF_BIT_BASE  = 8'hd8; // First bit address
	localparam logic [7:0] ADCSF_RESET     = 8'h00;
	localparam logic [7:0] ADCSF_USED_MASK = 8'hfc; // Bits 1:0 unused

	// ****************************************
	// Field positions
	// ****************************************
	localparam logic [2:0] ADCSF_RDY_PRI = 3'h7;
	localparam logic [2:0] ADCSF_RDY_AUX = 3'h6;
	localparam logic [2:0] ADCSF_CAL     = 3'h5;
	localparam logic [2:0] ADCSF_NOREF   = 3'h4;
	localparam logic [2:0] ADCSF_ERR_PRI = 3'h3;
	localparam logic [2:0] ADCSF_ERR_AUX = 3'h2;

	// Default converter result width
	localparam int ADCSF_RES_W = 24;
endpackage

//--- design/adcsf_status.sv
// Converter status flag register for a primary and an auxiliary converter.
// Assumes all converter-side inputs are on clk_sys; ref_bad comes from
// a pin comparator and is synchronised here.
// Behaviour
// RULE1 - Bit-addressable status byte at D8, resets 00
// RULE2 - Primary ready sets on conversion or calibration
// RULE3 - Primary ready clears by zero write, calibration start
// RULE4 - Set primary ready blocks result and calibration writes
// RULE5 - Auxiliary ready behaves like primary ready
// RULE6 - Calibration flag sets only on calibration finish
// RULE7 - Calibration flag clears only on mode write
// RULE8 - Auxiliary calibration on temperature sensor never completes
// RULE9 - Missing reference flags while any converter active
// RULE10 - Missing reference forces results to all ones
// RULE11 - Only first reference pair checked, clears when valid
// RULE12 - Primary error sets on clamped result
// RULE13 - Primary error flags failed calibration write
// RULE14 - Primary error clears on conversion or calibration start
// RULE15 - Auxiliary error behaves like primary error
// RULE16 - Writes to bits 1 and 0 ignored
// RULE17 - Bits 1 and 0 read as zero
// RULE18 - Hardware set beats software clear
`timescale 1ns/100ps
module adcsf_status #(
	parameter int RES_W = adcsf_pkg::ADCSF_RES_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic [7:0]       sfr_addr,
	input  wire logic             sfr_wr,
	input  wire logic [7:0]       sfr_wdata,
	input  wire logic             sfr_rd,
	output logic      [7:0]       sfr_rdata,
	input  wire logic             bit_wr,
	input  wire logic [7:0]       bit_addr,
	input  wire logic             bit_wdata,
	output logic                  bit_rdata,
	input  wire logic             pri_conv_valid,
	input  wire logic [RES_W-1:0] pri_conv_data,
	input  wire logic             pri_cal_done,
	input  wire logic             pri_cal_fail,
	input  wire logic             pri_mode_conv,
	input  wire logic             pri_mode_cal,
	input  wire logic             aux_conv_valid,
	input  wire logic [RES_W-1:0] aux_conv_data,
	input  wire logic             aux_cal_done,
	input  wire logic             aux_cal_fail,
	input  wire logic             aux_mode_conv,
	input  wire logic             aux_mode_cal,
	input  wire logic             aux_temp_sel,
	input  wire logic             adc_active,
	input  wire logic             ref_bad,
	output logic      [RES_W-1:0] pri_result,
	output logic                  pri_result_load,
	output logic                  pri_cal_load,
	output logic      [RES_W-1:0] aux_result,
	output logic                  aux_result_load,
	output logic                  aux_cal_load
);

	// ****************************************
	// Helpers
	// ****************************************
	// True when a value sits on either rail
	function automatic logic is_rail(input logic [RES_W-1:0] v);
		is_rail = (v == '0) || (v == '1);
	endfunction

	// ****************************************
	// Flag state
	// ****************************************
	logic [1:0]       rdy;     // Index 0 primary, 1 auxiliary
	logic [1:0]       err;
	logic             cal;
	logic             noref;
	logic             ref_s1;
	logic             ref_s2;
	logic [7:0]       status;

	// ****************************************
	// Register access decode
	// ****************************************
	logic             byte_wr;
	logic             bit_hit;
	logic [7:0]       sw_zero;
	logic             byte_hit_rd;

	assign byte_wr     = sfr_wr && (sfr_addr == adcsf_pkg::ADCSF_ADDR);
	assign byte_hit_rd = sfr_rd && (sfr_addr == adcsf_pkg::ADCSF_ADDR);
	assign bit_hit     = bit_addr[7:3] == adcsf_pkg::ADCSF_BIT_BASE[7:3];
	// Positions software wrote zero to; bits 1:0 masked off [RULE16]
	assign sw_zero = adcsf_pkg::ADCSF_USED_MASK & (byte_wr ? ~sfr_wdata :
		(bit_wr && bit_hit && !bit_wdata) ? (8'h01 << bit_addr[2:0]) : 8'h00);

	// Status byte image, unused bits zero [RULE1] [RULE17]
	assign status = {rdy[0], rdy[1], cal, noref, err[0], err[1], 2'b00};

	// ****************************************
	// Converter side
	// ****************************************
	logic [1:0]       cv;
	logic [1:0]       cd;
	logic [1:0]       cf;
	logic [1:0]       mconv;
	logic [1:0]       mcal;
	logic [1:0]       conv_acc;
	logic [1:0]       cal_acc;
	logic [1:0]       set_rdy;
	logic [1:0]       clr_rdy;
	logic [1:0]       set_err;
	logic [1:0]       clr_err;
	logic [1:0]       next_rdy;
	logic [1:0]       next_err;
	logic             next_cal;
	logic             next_noref;
	logic             mode_wr;
	logic [RES_W-1:0] wr_val [2];
	logic [RES_W-1:0] res [2];
	logic [1:0]       res_load;
	logic [1:0]       cal_load;

	assign cv    = {aux_conv_valid, pri_conv_valid};
	// Temperature-sensor calibration is dropped, never completes [RULE8]
	assign cd    = {aux_cal_done && !aux_temp_sel, pri_cal_done};
	assign cf    = {aux_cal_fail, pri_cal_fail};
	assign mconv = {aux_mode_conv, pri_mode_conv};
	assign mcal  = {aux_mode_cal, pri_mode_cal};

	// Nothing lands while ready is still up [RULE4] [RULE5]
	assign conv_acc = cv & ~rdy;
	assign cal_acc  = cd & ~rdy;

	// Result written, forced to ones on missing reference [RULE10]
	assign wr_val[0] = noref ? '1 : pri_conv_data;
	assign wr_val[1] = noref ? '1 : aux_conv_data;

	// Ready set on completion, cleared by zero write or cal start [RULE2] [RULE3] [RULE5]
	assign set_rdy = conv_acc | cal_acc;
	assign clr_rdy = {sw_zero[adcsf_pkg::ADCSF_RDY_AUX], sw_zero[adcsf_pkg::ADCSF_RDY_PRI]} | mcal;

	// Error on rail result or failed cal write [RULE12] [RULE13] [RULE15]
	assign set_err[0] = (conv_acc[0] && is_rail(wr_val[0])) || (cal_acc[0] && cf[0]);
	assign set_err[1] = (conv_acc[1] && is_rail(wr_val[1])) || (cal_acc[1] && cf[1]);
	assign clr_err    = mconv | mcal; // [RULE14] [RULE15]

	// Set beats clear so no event is lost [RULE18]
	assign next_rdy = set_rdy | (rdy & ~clr_rdy);
	assign next_err = set_err | (err & ~clr_err);

	// Calibration flag: set by finish, cleared only by a mode write [RULE6] [RULE7]
	assign mode_wr  = |(mconv | mcal);
	assign next_cal = (|cal_acc) || (cal && !mode_wr);

	// First reference pair only; second pair has no input here [RULE9] [RULE11]
	assign next_noref = adc_active && ref_s2;

	// ****************************************
	// Reference pin synchroniser
	// ****************************************
	// Two stages; comparator output is asynchronous to clk_sys
	// Only the second stage feeds logic, the first may still be settling
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ref_s1 <= 1'b0;
			ref_s2 <= 1'b0;
		end else begin
			ref_s1 <= ref_bad;
			ref_s2 <= ref_s1;
		end
	end

	// ****************************************
	// Flag registers
	// ****************************************
	// Power-on value 00 [RULE1]
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdy   <= 2'b00;
			err   <= 2'b00;
			cal   <= 1'b0;
			noref <= 1'b0;
		end else begin
			rdy   <= next_rdy;
			err   <= next_err;
			cal   <= next_cal;
			noref <= next_noref;
		end
	end

	// ****************************************
	// Result registers and load strobes
	// ****************************************
	// Cal registers only update on a clean calibration
	assign res_load = conv_acc;
	assign cal_load = cal_acc & ~cf;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			res[0] <= '0;
			res[1] <= '0;
		end else begin
			if (res_load[0]) begin
				res[0] <= wr_val[0];
			end
			if (res_load[1]) begin
				res[1] <= wr_val[1];
			end
		end
	end

	// Strobes registered so outputs come from flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pri_result_load <= 1'b0;
			aux_result_load <= 1'b0;
			pri_cal_load    <= 1'b0;
			aux_cal_load    <= 1'b0;
		end else begin
			pri_result_load <= res_load[0];
			aux_result_load <= res_load[1];
			pri_cal_load    <= cal_load[0];
			aux_cal_load    <= cal_load[1];
		end
	end

	assign pri_result = res[0];
	assign aux_result = res[1];

	// ****************************************
	// Read data
	// ****************************************
	// Read data lags the request by one edge; other addresses read zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= adcsf_pkg::ADCSF_RESET;
			bit_rdata <= 1'b0;
		end else begin
			sfr_rdata <= byte_hit_rd ? status : 8'h00; // [RULE1] [RULE17]
			bit_rdata <= bit_hit && status[bit_addr[2:0]];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// Register image, byte view then bit view
	AST_READ_IMAGE: assert property (byte_hit_rd |=> sfr_rdata == $past(status)) // [RULE1]
		else $error("status read mismatch");
	AST_BIT_READ: assert property (bit_hit |=> bit_rdata == $past(status[bit_addr[2:0]])) // [RULE1]
		else $error("status bit read mismatch");

	// Ready flags and the result blocking they cause
	AST_PRI_SET: assert property (pri_conv_valid && !rdy[0] |=> rdy[0] ##0 pri_result_load) // [RULE2]
		else $error("primary ready not set");
	AST_PRI_CLR: assert property (rdy[0] && pri_mode_cal && !set_rdy[0] |=> !rdy[0]) // [RULE3]
		else $error("primary ready not cleared");
	AST_PRI_BLOCK: assert property (rdy[0] |=> $stable(pri_result) && !pri_result_load && !pri_cal_load) // [RULE4]
		else $error("primary result written while ready");
	AST_AUX_SET: assert property (aux_conv_valid && !rdy[1] |=> rdy[1] && aux_result_load) // [RULE5]
		else $error("auxiliary ready not set");
	AST_AUX_BLOCK: assert property (rdy[1] |=> $stable(aux_result) && !aux_result_load && !aux_cal_load) // [RULE5]
		else $error("auxiliary result written while ready");

	// Calibration flag; a dropped temperature calibration leaves no trace
	AST_CAL_CAUSE: assert property ($rose(cal) |-> $past(|cal_acc)) // [RULE6]
		else $error("calibration flag set without calibration");
	AST_CAL_CLR: assert property (cal && mode_wr && !(|cal_acc) |=> !cal) // [RULE7]
		else $error("calibration flag not cleared");
	AST_TEMP_CAL: assert property (aux_temp_sel && aux_cal_done && !aux_conv_valid && !pri_cal_done // [RULE8]
		|=> !aux_cal_load && !$rose(cal) && !$rose(rdy[1]))
		else $error("temperature calibration completed");

	// Missing reference follows the pin two edges late, plus the flag edge
	AST_NOREF: assert property ((adc_active && ref_bad)[*3] |=> noref) // [RULE9] [RULE11]
		else $error("missing reference not flagged");
	AST_NOREF_CLR: assert property ((!ref_bad)[*3] |=> !noref) // [RULE11]
		else $error("missing reference not cleared");
	AST_NOREF_IDLE: assert property (!adc_active |=> !noref) // [RULE9]
		else $error("missing reference flagged while idle");
	AST_FORCE_ONES: assert property (pri_result_load && $past(noref) |-> pri_result == '1) // [RULE10]
		else $error("result not forced to ones");

	// Error flags, unused bits and ready set-over-clear priority
	AST_ERR_RAIL: assert property (conv_acc[0] && is_rail(wr_val[0]) |=> err[0]) // [RULE12] [RULE18]
		else $error("primary error not set");
	AST_ERR_CAL: assert property (cal_acc[0] && pri_cal_fail |=> err[0] && !pri_cal_load) // [RULE13]
		else $error("failed calibration not flagged");
	AST_ERR_CLR: assert property (err[1] && aux_mode_conv && !set_err[1] |=> !err[1]) // [RULE14] [RULE15]
		else $error("auxiliary error not cleared");
	AST_UNUSED: assert property (sfr_rdata[1:0] == 2'b00) // [RULE16] [RULE17]
		else $error("unused bits read nonzero");
	AST_SET_WINS: assert property (set_rdy[0] && sw_zero[adcsf_pkg::ADCSF_RDY_PRI] |=> rdy[0]) // [RULE18]
		else $error("set lost to clear");

	// Main scenarios that should be seen at least once
	COV_CONV_READY: cover property (pri_conv_valid && !rdy[0] ##1 rdy[0] ##[1:8] !rdy[0]);
	COV_CAL_DONE: cover property (aux_cal_done && !aux_temp_sel && !rdy[1] ##1 cal);
	COV_NOREF: cover property (noref ##0 pri_result_load);
	COV_SET_CLR: cover property (set_rdy[0] && sw_zero[adcsf_pkg::ADCSF_RDY_PRI]);
	COV_TEMP_CAL: cover property (aux_temp_sel && aux_cal_done);

endmodule

//--- testbench/adcsf_conv_model.sv
// Behavioural model of the primary and auxiliary converter engines.
// Assumes the bench calls its tasks just after a rising clk_sys edge.
`timescale 1ns/100ps
module adcsf_conv_model #(
	parameter int RES_W = 24
) (
	input  wire logic             clk_sys,
	output logic                  pri_conv_valid,
	output logic      [RES_W-1:0] pri_conv_data,
	output logic                  pri_cal_done,
	output logic                  pri_cal_fail,
	output logic                  aux_conv_valid,
	output logic      [RES_W-1:0] aux_conv_data,
	output logic                  aux_cal_done,
	output logic                  aux_cal_fail
);
	// ****************************************
	// Event pulses, index 0 primary, 1 auxiliary
	// ****************************************
	logic [1:0]       cv = 2'h0;
	logic [1:0]       cd = 2'h0;
	logic [1:0]       cf = 2'h0;
	logic [RES_W-1:0] dat [2] = '{default: '0};

	// Fan out to the two converter ports
	assign pri_conv_valid = cv[0];
	assign aux_conv_valid = cv[1];
	assign pri_cal_done   = cd[0];
	assign aux_cal_done   = cd[1];
	assign pri_cal_fail   = cf[0];
	assign aux_cal_fail   = cf[1];
	assign pri_conv_data  = dat[0];
	assign aux_conv_data  = dat[1];

	// One-cycle result; data inverted once released so stale values never match
	task automatic conv(input int k, input logic [RES_W-1:0] x);
		cv[k] = 1'b1;
		dat[k] = x;
		@(posedge clk_sys);
		#1;
		cv[k] = 1'b0;
		dat[k] = ~x;
	endtask

	// One-cycle calibration finish, fail only qualifies the finish
	task automatic cal(input int k, input logic fl);
		cd[k] = 1'b1;
		cf[k] = fl;
		@(posedge clk_sys);
		#1;
		cd[k] = 1'b0;
		cf[k] = ~fl;
	endtask
endmodule

//--- testbench/adcsf_status_test.sv
// Self-checking bench for the converter status flag register.
// Assumes the converter model supplies results and calibration events.
`timescale 1ns/100ps
module adcsf_status_test;
	localparam int RES_W = adcsf_pkg::ADCSF_RES_W;
	logic             clk_sys = 1'b0;
	logic             rstn = 1'b0;
	logic [7:0]       sfr_addr = 8'hd8;
	logic             sfr_wr = 1'b0;
	logic [7:0]       sfr_wdata = 8'h00;
	logic             sfr_rd = 1'b0;
	logic             bit_wr = 1'b0;
	logic [7:0]       bit_addr = 8'hd8;
	logic             bit_wdata = 1'b0;
	logic [3:0]       mode = 4'h0; // Aux cal, aux conv, pri cal, pri conv
	logic             aux_temp_sel = 1'b0;
	logic             adc_active = 1'b0;
	logic             ref_bad = 1'b0;
	logic [7:0]       sfr_rdata;
	logic             bit_rdata;
	logic [RES_W-1:0] pri_conv_data, aux_conv_data, pri_result, aux_result;
	logic             pri_conv_valid, pri_cal_done, pri_cal_fail, aux_conv_valid, aux_cal_done, aux_cal_fail;
	logic             pri_result_load, pri_cal_load, aux_result_load, aux_cal_load;
	int               miscompares = 0;
	int               n_compared = 0;

	// ****************************************
	// Clock, design and converter model
	// ****************************************
	always #2 clk_sys = ~clk_sys;

	adcsf_status #(.RES_W(RES_W)) i_adcsf_status (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr),
		.bit_addr(bit_addr), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .pri_conv_valid(pri_conv_valid),
		.pri_conv_data(pri_conv_data), .pri_cal_done(pri_cal_done), .pri_cal_fail(pri_cal_fail),
		.pri_mode_conv(mode[0]), .pri_mode_cal(mode[1]), .aux_conv_valid(aux_conv_valid),
		.aux_conv_data(aux_conv_data), .aux_cal_done(aux_cal_done), .aux_cal_fail(aux_cal_fail),
		.aux_mode_conv(mode[2]), .aux_mode_cal(mode[3]), .aux_temp_sel(aux_temp_sel), .adc_active(adc_active),
		.ref_bad(ref_bad), .pri_result(pri_result), .pri_result_load(pri_result_load),
		.pri_cal_load(pri_cal_load), .aux_result(aux_result), .aux_result_load(aux_result_load),
		.aux_cal_load(aux_cal_load));

	adcsf_conv_model #(.RES_W(RES_W)) i_adcsf_conv_model (.clk_sys(clk_sys), .pri_conv_valid(pri_conv_valid),
		.pri_conv_data(pri_conv_data), .pri_cal_done(pri_cal_done), .pri_cal_fail(pri_cal_fail),
		.aux_conv_valid(aux_conv_valid), .aux_conv_data(aux_conv_data), .aux_cal_done(aux_cal_done),
		.aux_cal_fail(aux_cal_fail));

	// ****************************************
	// Bus cycles and comparisons, all entered just after an edge
	// ****************************************
	task automatic stat(input logic [7:0] e);
		sfr_rd = 1'b1;
		@(posedge clk_sys);
		#1;
		sfr_rd = 1'b0;
		n_compared++;
		if (sfr_rdata !== e) begin
			$display("CHECK FAILED status expected %h seen %h", e, sfr_rdata);
			miscompares++;
		end
	endtask

	task automatic chk(input string what, input logic [RES_W-1:0] e, input logic [RES_W-1:0] g);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
			miscompares++;
		end
	endtask

	task automatic wr(input logic [7:0] d);
		sfr_wr = 1'b1;
		sfr_wdata = d;
		@(posedge clk_sys);
		#1;
		sfr_wr = 1'b0;
	endtask

	task automatic bw(input logic [2:0] n, input logic v);
		bit_wr = 1'b1;
		bit_addr = 8'hd8 + {5'h00, n};
		bit_wdata = v;
		@(posedge clk_sys);
		#1;
		bit_wr = 1'b0;
	endtask

	task automatic pm(input int i);
		mode[i] = 1'b1;
		@(posedge clk_sys);
		#1;
		mode[i] = 1'b0;
	endtask

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Clamped result, blocked result, both clear paths of ready, conversion-start clear of error
	task automatic s_primary();
		i_adcsf_conv_model.conv(0, 24'h000000);
		chk("pri load", 24'h1, {23'h0, pri_result_load});
		chk("pri result", 24'h0, pri_result);
		stat(8'h88);
		i_adcsf_conv_model.conv(0, 24'h123456);
		chk("pri blocked", 24'h0, {23'h0, pri_result_load});
		chk("pri held", 24'h0, pri_result);
		bw(3'h7, 1'b0);
		stat(8'h08);
		pm(0);
		stat(8'h00);
		i_adcsf_conv_model.conv(0, 24'h123456);
		chk("pri value", 24'h123456, pri_result);
		pm(1);
		stat(8'h00);
		i_adcsf_conv_model.cal(0, 1'b0);
		chk("pri cal load", 24'h1, {23'h0, pri_cal_load});
		stat(8'ha0);
		pm(1);
		stat(8'h00);
	endtask

	// Failed and good auxiliary calibration, temperature sensor lockout
	task automatic s_aux();
		i_adcsf_conv_model.cal(1, 1'b1);
		chk("aux cal fail load", 24'h0, {23'h0, aux_cal_load});
		stat(8'h64);
		pm(3);
		stat(8'h00);
		i_adcsf_conv_model.cal(1, 1'b0);
		chk("aux cal load", 24'h1, {23'h0, aux_cal_load});
		wr(8'h00);
		stat(8'h20);
		pm(2);
		aux_temp_sel = 1'b1;
		i_adcsf_conv_model.cal(1, 1'b0);
		aux_temp_sel = 1'b0;
		stat(8'h00);
	endtask

	// Missing reference only while active; forces ones; ready set beats clear
	task automatic s_ref();
		adc_active = 1'b1;
		ref_bad = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		stat(8'h10);
		i_adcsf_conv_model.conv(1, 24'h000001);
		chk("aux forced", {RES_W{1'b1}}, aux_result);
		chk("aux load", 24'h1, {23'h0, aux_result_load});
		i_adcsf_conv_model.conv(0, 24'h000001);
		chk("pri forced", {RES_W{1'b1}}, pri_result);
		pm(1);
		ref_bad = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		stat(8'h44);
		adc_active = 1'b0;
		ref_bad = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		ref_bad = 1'b0;
		stat(8'h44);
		pm(2);
		stat(8'h40);
		bw(3'h6, 1'b0);
		fork
			i_adcsf_conv_model.conv(1, 24'h000007);
			wr(8'h00);
		join
		stat(8'h40);
		chk("bit read", 24'h1, {23'h0, bit_rdata});
		wr(8'hff);
		bw(3'h1, 1'b1);
		@(posedge clk_sys);
		#1;
		bw(3'h0, 1'b1);
		stat(8'h40);
		bw(3'h6, 1'b0);
		stat(8'h00);
	endtask

	// Main sequence and hang guard
	initial begin
		repeat (4) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		stat(8'h00);
		s_primary();
		s_aux();
		s_ref();
		wrap_up();
	end

	initial begin
		#40000;
		miscompares++;
		wrap_up();
	end
endmodule
